/* File: lmbs_pkg.sv */
// Constants and types shared by the LIN mode and baud setup block.
// Assumes the core reaches the control byte over the special-function register port.
package lmbs_pkg;

  // ***************************************************************
  // Control byte location
  // ***************************************************************
  localparam logic [7:0] LMBS_CTRL_ADDR = 8'hC9;
  localparam logic [7:0] LMBS_CTRL_PAGE = 8'h0F;

  // ***************************************************************
  // Control byte fields
  // ***************************************************************
  localparam int LMBS_BIT_EN = 7;
  localparam int LMBS_BIT_MASTER = 6;
  localparam int LMBS_BIT_AUTO_BAUD_SELECT = 5;
  localparam logic [7:0] LMBS_RSVD_MASK = 8'h1F;
  localparam logic LMBS_RST_EN = 1'h0;
  localparam logic LMBS_RST_MASTER = 1'h1;
  localparam logic LMBS_RST_AUTO_BAUD_SELECT = 1'h1;
  localparam logic [7:0] LMBS_RST_BYTE = 8'h60;

  // ***************************************************************
  // Baud generator sizing
  // ***************************************************************
  localparam int LMBS_PRESC_W = 3;
  localparam int LMBS_DIV_W = 16;
  localparam int LMBS_PRE_CNT_W = 9;
  localparam logic [LMBS_PRE_CNT_W-1:0] LMBS_PRE_BASE = 9'h002;
  localparam logic [LMBS_PRE_CNT_W-1:0] LMBS_PRE_ONE = 9'h001;

  // Operating role as seen by the rest of the controller
  typedef enum logic [1:0] {
    LMBS_OFF,
    LMBS_MASTER,
    LMBS_SLAVE_MANUAL,
    LMBS_SLAVE_AUTO
  } lmbs_mode_t;

endpackage

/* File: lmbs_baud_if.sv */
// Carrier between the control register logic and the automatic baud generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface lmbs_baud_if #(
  parameter int DIV_W = lmbs_pkg::LMBS_DIV_W
);
  logic run;
  logic [lmbs_pkg::LMBS_PRESC_W-1:0] prescale;
  logic [DIV_W-1:0] divider;
  logic tick;

  modport ctrl (output run, output prescale, output divider, input tick);
  modport gen (input run, input prescale, input divider, output tick);
endinterface

/* File: lmbs_baud_gen.sv */
// Automatic-mode baud tick generator: system clock / 2^(prescale+1) / divider.
// Assumes prescale and divider are held steady while run is high.
`timescale 1ns/1ps
module lmbs_baud_gen
  import lmbs_pkg::*;
#(
  parameter int DIV_W = LMBS_DIV_W
) (
  input wire logic ref_clk_i, // System clock
  input wire logic srst_i,    // Synchronous reset, active high
  lmbs_baud_if.gen bif        // Control side
);
  import lmbs_pkg::*;

  typedef struct packed {
    logic [LMBS_PRE_CNT_W-1:0] pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
  } lmbs_gen_st_t;

  lmbs_gen_st_t st;
  lmbs_gen_st_t next_st;
  logic [LMBS_PRE_CNT_W-1:0] pre_lim;
  logic pre_wrap;
  logic div_wrap;

  // ***************************************************************
  // Counting
  // ***************************************************************
  always_comb begin
    next_st = st;
    pre_lim = (LMBS_PRE_BASE << bif.prescale) - LMBS_PRE_ONE;
    pre_wrap = (st.pre_cnt >= pre_lim);
    // A divider of 0 or 1 gives one tick per prescaler wrap
    div_wrap = ((st.div_cnt + DIV_W'(1)) >= bif.divider);
    next_st.tick = 1'b0;
    if (!bif.run) begin
      next_st.pre_cnt = '0;
      next_st.div_cnt = '0;
    end else if (pre_wrap) begin
      next_st.pre_cnt = '0;
      if (div_wrap) begin
        next_st.div_cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + DIV_W'(1);
      end
    end else begin
      next_st.pre_cnt = st.pre_cnt + LMBS_PRE_ONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bif.tick = st.tick;

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_tick_needs_run: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    st.tick |-> $past(bif.run)) else $error("Baud tick without run");
  a_tick_single: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    st.tick |=> !st.tick) else $error("Baud tick longer than one cycle");
  a_idle_cleared: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !bif.run |=> (st.pre_cnt == '0) && (st.div_cnt == '0))
    else $error("Counters not cleared while stopped");
  c_gen_tick: cover property (@(posedge ref_clk_i) disable iff (srst_i) st.tick);
endmodule

/* File: lmbs_top.sv */
// Control mode byte of the LIN controller with role and baud-source decode.
// Assumes a single-cycle SFR port from the core and prescale/divider held in
// neighbouring registers outside this block.
`timescale 1ns/1ps

// Operation
// - Bit 7 turns the controller off at 0, on at 1; resets to 0.
// - Bit 6 selects slave at 0, master at 1; resets to master.
// - Bit 5 matters only in slave role; ignored in master role.
// - In slave role bit 5 picks manual at 0, automatic at 1; resets to 1.
// - Bits 4 to 0 read as zero and writes to them are dropped.
module lmbs_top
  import lmbs_pkg::*;
#(
  parameter int DIV_W = LMBS_DIV_W
) (
  input wire logic ref_clk_i,                     // System clock, 40 MHz
  input wire logic srst_i,                        // Synchronous reset, active high
  input wire logic [7:0] sfr_addr_i,              // SFR address
  input wire logic [7:0] sfr_page_i,              // Current SFR page
  input wire logic sfr_wr_i,                      // SFR write strobe
  input wire logic sfr_rd_i,                      // SFR read strobe
  input wire logic [7:0] sfr_wdata_i,             // SFR write data
  output logic [7:0] sfr_rdata_o,                 // SFR read data, one cycle later
  input wire logic [lmbs_pkg::LMBS_PRESC_W-1:0] prescale_i, // Prescaler setting
  input wire logic [DIV_W-1:0] divider_i,         // Divider setting
  output logic lin_enable_o,                      // Controller enabled
  output logic master_mode_o,                     // Enabled and acting as master
  output logic auto_baud_active_o,                // Enabled slave, automatic baud
  output logic manual_baud_active_o,              // Enabled slave, manual baud
  output lmbs_pkg::lmbs_mode_t mode_o, // Decoded operating role
  output logic baud_tick_o                        // Automatic-mode baud tick
);
  import lmbs_pkg::*;

  typedef struct packed {
    logic en;
    logic master;
    logic auto_baud_select;
    logic [7:0] rdata;
    logic master_on;
    logic auto_on;
    logic manual_on;
    lmbs_mode_t mode;
    logic tick;
  } lmbs_top_st_t;

  lmbs_top_st_t st;
  lmbs_top_st_t next_st;
  logic hit;
  logic [7:0] ctrl_byte;

  lmbs_baud_if #(.DIV_W(DIV_W)) bif ();

  // ***************************************************************
  // Register access and decode
  // ***************************************************************
  // The page must match too: the same address holds other registers on other pages
  assign hit = (sfr_addr_i == LMBS_CTRL_ADDR) && (sfr_page_i == LMBS_CTRL_PAGE);

  always_comb begin
    next_st = st;
    ctrl_byte = 8'h00;
    ctrl_byte[LMBS_BIT_EN] = st.en;
    ctrl_byte[LMBS_BIT_MASTER] = st.master;
    ctrl_byte[LMBS_BIT_AUTO_BAUD_SELECT] = st.auto_baud_select;
    // Read returns the value before a same-cycle write
    next_st.rdata = 8'h00;
    if (sfr_rd_i && hit) begin
      next_st.rdata = ctrl_byte & ~LMBS_RSVD_MASK;
    end
    if (sfr_wr_i && hit) begin
      next_st.en = sfr_wdata_i[LMBS_BIT_EN];
      next_st.master = sfr_wdata_i[LMBS_BIT_MASTER];
      next_st.auto_baud_select = sfr_wdata_i[LMBS_BIT_AUTO_BAUD_SELECT];
    end
    // Decode from next values so outputs line up with the register bits
    next_st.master_on = next_st.en && next_st.master;
    next_st.auto_on = next_st.en && !next_st.master && next_st.auto_baud_select;
    next_st.manual_on = next_st.en && !next_st.master && !next_st.auto_baud_select;
    if (!next_st.en) begin
      next_st.mode = LMBS_OFF;
    end else if (next_st.master) begin
      next_st.mode = LMBS_MASTER;
    end else if (next_st.auto_baud_select) begin
      next_st.mode = LMBS_SLAVE_AUTO;
    end else begin
      next_st.mode = LMBS_SLAVE_MANUAL;
    end
    next_st.tick = bif.tick;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st.en <= LMBS_RST_EN;
      st.master <= LMBS_RST_MASTER;
      st.auto_baud_select <= LMBS_RST_AUTO_BAUD_SELECT;
      st.rdata <= 8'h00;
      st.master_on <= 1'b0;
      st.auto_on <= 1'b0;
      st.manual_on <= 1'b0;
      st.mode <= LMBS_OFF;
      st.tick <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // Automatic baud generator
  // ***************************************************************
  // Run comes from auto_on, prescale and divider set the rate; no multiplier is used here
  assign bif.run = st.auto_on;
  assign bif.prescale = prescale_i;
  assign bif.divider = divider_i;

  lmbs_baud_gen #(.DIV_W(DIV_W)) u_baud_gen (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .bif(bif)
  );

  assign sfr_rdata_o = st.rdata;
  assign lin_enable_o = st.en;
  assign master_mode_o = st.master_on;
  assign auto_baud_active_o = st.auto_on;
  assign manual_baud_active_o = st.manual_on;
  assign mode_o = st.mode;
  assign baud_tick_o = st.tick;

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_reset_state: assert property (@(posedge ref_clk_i)
    $past(srst_i) && srst_i |=> !lin_enable_o && st.master && st.auto_baud_select)
    else $error("Wrong control value after reset");
  a_enable_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sfr_wr_i && hit ##1 sfr_rd_i && hit && !sfr_wr_i
    |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & ~LMBS_RSVD_MASK))
    else $error("Read back differs from write");
  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (sfr_rdata_o & LMBS_RSVD_MASK) == 8'h00) else $error("Reserved bits not zero");
  a_master_ignores: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_mode_o |-> !auto_baud_active_o && !manual_baud_active_o && mode_o == LMBS_MASTER)
    else $error("Baud select active in master role");
  a_slave_select: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    lin_enable_o && !st.master |-> auto_baud_active_o == st.auto_baud_select
    && manual_baud_active_o == !st.auto_baud_select) else $error("Slave baud source wrong");
  a_off_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !lin_enable_o |-> mode_o == LMBS_OFF && !master_mode_o && !auto_baud_active_o)
    else $error("Role active while disabled");
  a_tick_gated: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    baud_tick_o |-> $past(auto_baud_active_o, 2)) else $error("Tick outside auto mode");
  a_miss_reads_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !(sfr_rd_i && hit) |=> sfr_rdata_o == 8'h00) else $error("Data without read hit");

  // ***************************************************************
  // Register write and read checks
  // ***************************************************************
  a_enable_lands: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sfr_wr_i && hit |=> lin_enable_o == $past(sfr_wdata_i[LMBS_BIT_EN]))
    else $error("Enable bit not taken from write");
  a_role_lands: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sfr_wr_i && hit |=> st.master == $past(sfr_wdata_i[LMBS_BIT_MASTER]))
    else $error("Role bit not taken from write");
  a_auto_baud_select_lands: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sfr_wr_i && hit |=> st.auto_baud_select == $past(sfr_wdata_i[LMBS_BIT_AUTO_BAUD_SELECT]))
    else $error("Baud select bit not taken from write");
  a_bits_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !(sfr_wr_i && hit) |=> $stable({lin_enable_o, st.master, st.auto_baud_select}))
    else $error("Control bits changed without a write");
  a_read_old: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sfr_rd_i && hit
    |=> sfr_rdata_o == {$past(lin_enable_o), $past(st.master), $past(st.auto_baud_select), 5'h00})
    else $error("Read data differs from control bits");
  a_reset_quiet: assert property (@(posedge ref_clk_i)
    $past(srst_i) && srst_i |=> mode_o == LMBS_OFF && !master_mode_o && !auto_baud_active_o
    && !manual_baud_active_o && !baud_tick_o && sfr_rdata_o == 8'h00)
    else $error("Outputs active after reset");

  // ***************************************************************
  // Role decode checks
  // ***************************************************************
  a_master_decode: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_mode_o == (lin_enable_o && st.master))
    else $error("Master role decode wrong");
  a_auto_mode: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    auto_baud_active_o |-> mode_o == LMBS_SLAVE_AUTO)
    else $error("Automatic baud mode code wrong");
  a_manual_mode: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    manual_baud_active_o |-> mode_o == LMBS_SLAVE_MANUAL)
    else $error("Manual baud mode code wrong");
  a_one_role: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $onehot0({master_mode_o, auto_baud_active_o, manual_baud_active_o}))
    else $error("More than one role active");
  a_on_has_role: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    lin_enable_o |-> mode_o != LMBS_OFF)
    else $error("Enabled controller shows no role");

  // ***************************************************************
  // Baud source checks
  // ***************************************************************
  // A tick already in the two-stage pipe may still leave after a role change
  a_off_no_tick: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !lin_enable_o ##1 !lin_enable_o |=> !baud_tick_o)
    else $error("Tick while disabled");
  a_master_no_tick: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_mode_o ##1 master_mode_o |=> !baud_tick_o)
    else $error("Tick in master role");
  a_master_no_run: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_mode_o |-> !bif.run)
    else $error("Baud generator runs in master role");

  c_auto_slave: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    auto_baud_active_o && baud_tick_o);
  c_write_read: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    sfr_wr_i && hit ##1 sfr_rd_i && hit);
  c_manual_slave: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    mode_o == LMBS_SLAVE_MANUAL);
  c_master_on: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(master_mode_o));
endmodule

/* File: lmbs_sw_model.sv */
// Software-side partner: works out the automatic-mode baud settings from the clock rate.
// Assumes a clock rate of at least 8 MHz, so that the prescaler never goes negative.
`timescale 1ns/1ps
module lmbs_sw_model
  import lmbs_pkg::*;
#(
  parameter longint CLK_HZ = 40000000
) (
  output logic [LMBS_PRESC_W-1:0] prescale_o, // Prescaler setting
  output logic [LMBS_DIV_W-1:0] divider_o     // Divider setting
);
  // ***************************************************************
  // Automatic slave baud settings
  // ***************************************************************
  // Integer log2 of the clock ratio, so the divider uses the rounded-down prescaler
  function automatic int presc_of(input longint hz);
    int p;
    p = 0;
    while ((longint'(4000000) << (p + 1)) <= hz) p++;
    return p - 1;
  endfunction

  localparam int PRE = presc_of(CLK_HZ);
  localparam longint DIV = CLK_HZ / ((longint'(1) << (PRE + 1)) * 20000);

  // No multiplier is produced: automatic slave mode needs none
  assign prescale_o = PRE[LMBS_PRESC_W-1:0];
  assign divider_o = DIV[LMBS_DIV_W-1:0];
endmodule

/* File: test_lin_mode_and_baud_setup.sv */
// Self-checking bench for the LIN mode and baud setup block.
// Assumes the partner model supplies the prescaler and divider levels.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module test_lin_mode_and_baud_setup;
  import lmbs_pkg::*;
  localparam longint CLK_HZ = 40000000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] page = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [LMBS_PRESC_W-1:0] prescale;
  logic [LMBS_DIV_W-1:0] divider;
  logic en, mst, ab, mb, tick;
  lmbs_mode_t mode;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] v;
  int n, gap;

  always #12.5 clk = ~clk;

  lmbs_sw_model #(.CLK_HZ(CLK_HZ)) u_lmbs_sw_model (.prescale_o(prescale), .divider_o(divider));

  lmbs_top u_lmbs_top (
    .ref_clk_i(clk), .srst_i(srst), .sfr_addr_i(addr), .sfr_page_i(page),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .prescale_i(prescale), .divider_i(divider), .lin_enable_o(en),
    .master_mode_o(mst), .auto_baud_active_o(ab), .manual_baud_active_o(mb),
    .mode_o(mode), .baud_tick_o(tick)
  );

  // ***************************************************************
  // Access tasks
  // ***************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
    @(negedge clk);
    addr = a; page = pg; wdata = d; wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] pg, output logic [7:0] d);
    @(negedge clk);
    addr = a; page = pg; rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  // Write then read on the next strobe, or both on one strobe when same is set
  task automatic wr_rd(input logic [7:0] d, input logic same, output logic [7:0] q);
    @(negedge clk);
    addr = LMBS_CTRL_ADDR;
    page = LMBS_CTRL_PAGE;
    wdata = d;
    wr = 1'b1;
    rd = same;
    @(negedge clk);
    wr = 1'b0;
    rd = !same;
    if (!same) begin
      @(negedge clk);
      rd = 1'b0;
    end
    q = rdata;
  endtask

  task automatic chk_outs(input logic [3:0] ex, input lmbs_mode_t m);
    `CHK("flags", ex, {en, mst, ab, mb})
    `CHK("mode", m, mode)
  endtask

  // Counts ticks over a window and the spacing of the first two
  task automatic watch(input int win, output int cnt, output int sp);
    int last;
    cnt = 0; sp = 0; last = 0;
    for (int i = 0; i < win; i++) begin
      @(negedge clk);
      if (tick === 1'b1) begin
        if (cnt == 1) sp = i - last;
        last = i;
        cnt++;
      end
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 10500 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rd_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, v);
    `CHK("reset byte", 8'h60, v)
    chk_outs(4'h0, LMBS_OFF);
    wr_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, 8'hFF);
    chk_outs(4'hC, LMBS_MASTER);
    rd_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, v);
    `CHK("low bits", 8'hE0, v)
    watch(3000, n, gap);
    `CHK("master ticks", 0, n)
    wr_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, 8'hC0);
    chk_outs(4'hC, LMBS_MASTER);
    wr_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, 8'h80);
    chk_outs(4'h9, LMBS_SLAVE_MANUAL);
    rd_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, v);
    `CHK("manual byte", 8'h80, v)
    wr_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, 8'hA0);
    chk_outs(4'hA, LMBS_SLAVE_AUTO);
    watch(4500, n, gap);
    `CHK("auto ticks", 2, n)
    `CHK("bit period", int'(CLK_HZ / 20000), gap)
    wr_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, 8'h20);
    chk_outs(4'h0, LMBS_OFF);
    watch(3000, n, gap);
    `CHK("off ticks", 0, n)
    wr_reg(LMBS_CTRL_ADDR, 8'h00, 8'h80);
    wr_reg(8'hC8, LMBS_CTRL_PAGE, 8'h80);
    rd_reg(LMBS_CTRL_ADDR, LMBS_CTRL_PAGE, v);
    `CHK("unmapped write", 8'h20, v)
    rd_reg(LMBS_CTRL_ADDR, 8'h00, v);
    `CHK("wrong page read", 8'h00, v)
    chk_outs(4'h0, LMBS_OFF);
    wr_rd(8'hBF, 1'b1, v);
    `CHK("same cycle read", 8'h20, v)
    chk_outs(4'hA, LMBS_SLAVE_AUTO);
    wr_rd(8'h5F, 1'b0, v);
    `CHK("write then read", 8'h40, v)
    chk_outs(4'h0, LMBS_OFF);
    end_sim();
  end
endmodule
